//--- rtl/icmi_top.sv
`timescale 1ns/10ps
module icmi_top import icmi_pkg::*; (
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Event inputs
    input wire logic supply_fault_event,
    input wire logic comparator_event,
    // Serial pins, open drain
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Interrupt
    output logic irq
);

    icmi_state_type state_reg;
    logic [1:0] phase_reg;
    logic [7:0] qcnt_reg;
    logic [2:0] bit_cnt_reg;
    logic [1:0] byte_idx_reg;
    logic [7:0] shift_reg;
    logic samp_reg;
    logic rx_byte_reg;
    logic nack_reg;
    logic len_reg;
    logic read_mode_reg;
    logic [6:0] slave_addr_reg;
    logic [7:0] first_write_reg;
    logic [7:0] second_write_byte_reg;
    logic [7:0] read_byte_reg;
    logic [7:0] misc_irq_control_reg;
    logic wr_pend_reg;
    logic [31:0] wr_addr_reg;

    logic addr_taken;
    logic quarter_end;
    logic step_end;
    logic busy;
    logic go;
    logic finish;
    logic [7:0] ctrl_read;
    logic [7:0] rd_mux;

    function automatic logic [31:0] byte_addr(input logic [15:0] idx);
        byte_addr = {ADDR_TOP_ZERO, idx, ADDR_LOW_ZERO};
    endfunction : byte_addr

    function automatic logic hit(input logic [15:0] idx);
        hit = wr_pend_reg && (wr_addr_reg == byte_addr(idx));
    endfunction : hit

    assign addr_taken = hsel && htrans[1] && hready;
    assign busy = (state_reg != ST_IDLE);
    assign quarter_end = (qcnt_reg == QUARTER_LAST);
    assign step_end = quarter_end && (phase_reg == PHASE_LAST);
    assign go = hit(SERIAL_CTRL_IDX) && hwdata[CTRL_GO_BIT] && !busy;
    assign finish = (state_reg == ST_STOP) && step_end;
    assign ctrl_read = {busy, nack_reg, 3'b000, read_mode_reg, 1'b0, len_reg};

    always_comb begin
        rd_mux = BYTE_RESET;
        case (haddr)
            byte_addr(SERIAL_CTRL_IDX): rd_mux = ctrl_read;
            byte_addr(SLAVE_ADDR_IDX): rd_mux = {1'b0, slave_addr_reg};
            byte_addr(SECOND_WRITE_IDX): rd_mux = second_write_byte_reg;
            byte_addr(READ_BYTE_IDX): rd_mux = read_byte_reg;
            byte_addr(FIRST_WRITE_IDX): rd_mux = first_write_reg;
            byte_addr(MISC_IRQ_IDX): rd_mux = misc_irq_control_reg;
            default: rd_mux = BYTE_RESET;
        endcase
    end

    // Zero wait states: read data is fetched in the address phase, so a
    // read right behind a write to the same register sees the old value.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= WORD_ZERO;
            hrdata <= WORD_ZERO;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            wr_pend_reg <= addr_taken && hwrite;
            wr_addr_reg <= haddr;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_taken && !hwrite) begin
                hrdata <= {24'h000000, rd_mux};
            end
        end
    end

    // Software-owned configuration bytes.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            slave_addr_reg <= SLAVE_RESET;
            first_write_reg <= BYTE_RESET;
            second_write_byte_reg <= BYTE_RESET;
            len_reg <= 1'b0;
            read_mode_reg <= 1'b0;
        end else begin
            if (hit(SLAVE_ADDR_IDX)) begin
                slave_addr_reg <= hwdata[6:0];
            end
            if (hit(FIRST_WRITE_IDX)) begin
                first_write_reg <= hwdata[7:0];
            end
            if (hit(SECOND_WRITE_IDX)) begin
                second_write_byte_reg <= hwdata[7:0];
            end
            if (hit(SERIAL_CTRL_IDX) && !busy) begin
                len_reg <= hwdata[CTRL_LEN_BIT];
                read_mode_reg <= hwdata[CTRL_READ_BIT];
            end
        end
    end

    // Serial engine: every bit is four quarters; data is sampled at the end
    // of the second quarter and shifted in at the end of the fourth.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            phase_reg <= PHASE_FIRST;
            qcnt_reg <= QCNT_ZERO;
            bit_cnt_reg <= BIT_LAST;
            byte_idx_reg <= IDX_ADDR;
            shift_reg <= BYTE_RELEASED;
            samp_reg <= 1'b1;
            rx_byte_reg <= 1'b0;
            nack_reg <= 1'b0;
            read_byte_reg <= BYTE_RESET;
        end else if (go) begin
            state_reg <= ST_START;
            phase_reg <= PHASE_FIRST;
            qcnt_reg <= QCNT_ZERO;
            bit_cnt_reg <= BIT_LAST;
            byte_idx_reg <= IDX_ADDR;
            shift_reg <= {slave_addr_reg, hwdata[CTRL_READ_BIT]};
            rx_byte_reg <= 1'b0;
            nack_reg <= 1'b0;
        end else if (busy) begin
            qcnt_reg <= quarter_end ? QCNT_ZERO : 8'(qcnt_reg + 8'h01);
            if (quarter_end) begin
                phase_reg <= 2'(phase_reg + 2'h1);
            end
            if (quarter_end && phase_reg == PHASE_SAMPLE) begin
                samp_reg <= sda_in;
            end
            if (step_end) begin
                case (state_reg)
                    ST_START: state_reg <= ST_BIT;
                    ST_BIT: begin
                        shift_reg <= {shift_reg[6:0], samp_reg};
                        bit_cnt_reg <= 3'(bit_cnt_reg - 3'h1);
                        if (bit_cnt_reg == 3'h0) begin
                            state_reg <= ST_ACK;
                        end
                    end
                    ST_ACK: begin
                        bit_cnt_reg <= BIT_LAST;
                        if (rx_byte_reg) begin
                            read_byte_reg <= shift_reg;
                            state_reg <= ST_STOP;
                        end else if (samp_reg) begin
                            nack_reg <= 1'b1;
                            state_reg <= ST_STOP;
                        end else if (byte_idx_reg == IDX_ADDR) begin
                            byte_idx_reg <= IDX_FIRST;
                            state_reg <= ST_BIT;
                            if (read_mode_reg) begin
                                shift_reg <= BYTE_RELEASED;
                                rx_byte_reg <= 1'b1;
                            end else begin
                                shift_reg <= first_write_reg;
                            end
                        end else if (byte_idx_reg == IDX_FIRST && len_reg) begin
                            byte_idx_reg <= IDX_SECOND;
                            shift_reg <= second_write_byte_reg;
                            state_reg <= ST_BIT;
                        end else begin
                            state_reg <= ST_STOP;
                        end
                    end
                    ST_STOP: state_reg <= ST_IDLE;
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // Pins follow the engine one cycle later; only low is ever driven.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            case (state_reg)
                ST_START: begin
                    scl_oe <= (phase_reg >= PHASE_MID);
                    sda_oe <= (phase_reg != PHASE_FIRST);
                end
                ST_BIT: begin
                    scl_oe <= phase_reg == PHASE_FIRST
                        || phase_reg == PHASE_LAST;
                    sda_oe <= !shift_reg[7];
                end
                ST_ACK: begin
                    scl_oe <= phase_reg == PHASE_FIRST
                        || phase_reg == PHASE_LAST;
                    sda_oe <= 1'b0;
                end
                ST_STOP: begin
                    scl_oe <= (phase_reg == PHASE_FIRST);
                    sda_oe <= (phase_reg <= PHASE_SAMPLE);
                end
                default: begin
                    scl_oe <= 1'b0;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // Flags: a hardware set always wins over a clear in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            misc_irq_control_reg <= BYTE_RESET;
        end else begin
            if (hit(MISC_IRQ_IDX)) begin
                misc_irq_control_reg[SUPPLY_EN_BIT] <=
                    hwdata[SUPPLY_EN_BIT];
                misc_irq_control_reg[SERIAL_EN_BIT] <=
                    hwdata[SERIAL_EN_BIT];
                misc_irq_control_reg[COMP_EN_BIT] <=
                    hwdata[COMP_EN_BIT];
            end
            if (finish) begin
                misc_irq_control_reg[SERIAL_FLAG_BIT] <= 1'b1;
            end else if (go || (hit(MISC_CLEAR_IDX)
                    && hwdata[SERIAL_FLAG_BIT])) begin
                misc_irq_control_reg[SERIAL_FLAG_BIT] <= 1'b0;
            end
            if (supply_fault_event) begin
                misc_irq_control_reg[SUPPLY_FLAG_BIT] <= 1'b1;
            end else if (hit(MISC_CLEAR_IDX) && hwdata[SUPPLY_FLAG_BIT]) begin
                misc_irq_control_reg[SUPPLY_FLAG_BIT] <= 1'b0;
            end
            if (comparator_event) begin
                misc_irq_control_reg[COMP_FLAG_BIT] <= 1'b1;
            end else if (hit(MISC_CLEAR_IDX) && hwdata[COMP_FLAG_BIT]) begin
                misc_irq_control_reg[COMP_FLAG_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((misc_irq_control_reg >> 1) & misc_irq_control_reg
                & (IRQ_EN_MASK >> 1));
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    two_byte_a: assert property (state_reg == ST_ACK && step_end
        && !rx_byte_reg && !samp_reg && byte_idx_reg == IDX_FIRST && len_reg
        |=> state_reg == ST_BIT && shift_reg == $past(second_write_byte_reg))
        else $error("second write byte not loaded");
    read_capture_a: assert property (state_reg == ST_ACK
        && step_end && rx_byte_reg
        |=> read_byte_reg == $past(shift_reg) && state_reg == ST_STOP)
        else $error("read byte not captured");
    done_set_a: assert property (finish
        |=> misc_irq_control_reg[SERIAL_FLAG_BIT] && !busy)
        else $error("completion flag not set");
    done_clear_a: assert property (go
        |=> !misc_irq_control_reg[SERIAL_FLAG_BIT] && state_reg == ST_START)
        else $error("completion flag not cleared at start");
    serial_mask_a: assert property (
        misc_irq_control_reg[SERIAL_FLAG_BIT]
        && !misc_irq_control_reg[SERIAL_EN_BIT]
        && !misc_irq_control_reg[SUPPLY_FLAG_BIT]
        && !misc_irq_control_reg[COMP_FLAG_BIT] |=> !irq)
        else $error("masked completion raised interrupt");
    supply_flag_a: assert property (supply_fault_event
        |=> misc_irq_control_reg[SUPPLY_FLAG_BIT])
        else $error("supply fault flag not set");
    comp_flag_a: assert property (comparator_event
        |=> misc_irq_control_reg[COMP_FLAG_BIT])
        else $error("comparator flag not set");
    reset_zero_a: assert property (
        @(posedge clk_sys) disable iff (1'b0)
        rst |=> read_byte_reg == BYTE_RESET
        && second_write_byte_reg == BYTE_RESET
        && misc_irq_control_reg == BYTE_RESET)
        else $error("registers not zero after reset");
    irq_level_a: assert property (##1 irq == $past(
        |(misc_irq_control_reg[SUPPLY_FLAG_BIT +: 2] == 2'h3)
        || misc_irq_control_reg[SERIAL_FLAG_BIT +: 2] == 2'h3
        || misc_irq_control_reg[COMP_FLAG_BIT +: 2] == 2'h3))
        else $error("interrupt does not follow flags and enables");
    nack_stop_a: assert property (state_reg == ST_ACK && step_end
        && !rx_byte_reg && samp_reg |=> nack_reg && state_reg == ST_STOP)
        else $error("slave refusal did not end the transfer");
    supply_clear_a: assert property (
        wr_pend_reg && wr_addr_reg == byte_addr(MISC_CLEAR_IDX)
        && hwdata[SUPPLY_FLAG_BIT] && !supply_fault_event
        |=> !misc_irq_control_reg[SUPPLY_FLAG_BIT])
        else $error("supply fault flag not cleared");
    enable_write_a: assert property (
        wr_pend_reg && wr_addr_reg == byte_addr(MISC_IRQ_IDX)
        |=> misc_irq_control_reg[SERIAL_EN_BIT]
            == $past(hwdata[SERIAL_EN_BIT])
        && misc_irq_control_reg[COMP_EN_BIT]
            == $past(hwdata[COMP_EN_BIT]))
        else $error("interrupt enables not written");

    two_byte_c: cover property (byte_idx_reg == IDX_SECOND && finish);
    read_c: cover property (rx_byte_reg && finish);
    nack_c: cover property ($rose(nack_reg));
    irq_c: cover property ($rose(irq));

endmodule : icmi_top

//--- common/icmi_pkg.sv
package icmi_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [15:0] SERIAL_CTRL_IDX = 16'hFF80;
    localparam logic [15:0] SLAVE_ADDR_IDX = 16'hFF81;
    localparam logic [15:0] SECOND_WRITE_IDX = 16'hFF82;
    localparam logic [15:0] READ_BYTE_IDX = 16'hFF83;
    localparam logic [15:0] FIRST_WRITE_IDX = 16'hFF84;
    localparam logic [15:0] MISC_IRQ_IDX = 16'hFF95;
    localparam logic [15:0] MISC_CLEAR_IDX = 16'hFF96;
    localparam logic [13:0] ADDR_TOP_ZERO = 14'h0000;
    localparam logic [1:0] ADDR_LOW_ZERO = 2'h0;

    // Control/status register fields.
    localparam int CTRL_LEN_BIT = 0;
    localparam int CTRL_GO_BIT = 1;
    localparam int CTRL_READ_BIT = 2;
    localparam int CTRL_NACK_BIT = 6;
    localparam int CTRL_BUSY_BIT = 7;

    // Combined interrupt control register fields.
    localparam int COMP_FLAG_BIT = 0;
    localparam int COMP_EN_BIT = 1;
    localparam int SERIAL_FLAG_BIT = 2;
    localparam int SERIAL_EN_BIT = 3;
    localparam int SUPPLY_FLAG_BIT = 4;
    localparam int SUPPLY_EN_BIT = 5;
    localparam logic [7:0] IRQ_EN_MASK = 8'h2A;

    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] BYTE_RELEASED = 8'hFF;
    localparam logic [6:0] SLAVE_RESET = 7'h00;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;

    // Serial timing: a bit is four quarter periods of 2500 ns (100 kHz).
    localparam int CLK_PERIOD_NS = 10;
    localparam int QUARTER_NS = 2500;
    localparam int QUARTER_CYCLES_INT = QUARTER_NS / CLK_PERIOD_NS;
    localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYCLES_INT - 1);
    localparam logic [7:0] QCNT_ZERO = 8'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] PHASE_FIRST = 2'h0;
    localparam logic [1:0] PHASE_SAMPLE = 2'h1;
    localparam logic [1:0] PHASE_MID = 2'h2;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_FIRST = 2'h1;
    localparam logic [1:0] IDX_SECOND = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_BIT = 3'b010,
        ST_ACK = 3'b011,
        ST_STOP = 3'b100
    } icmi_state_type;

endpackage : icmi_pkg

//--- dv/icmi_slave_model.sv
`timescale 1ns/10ps
module icmi_slave_model #(
    parameter logic [7:0] READ_VALUE = 8'h5A,
    parameter logic [6:0] OWN_ADDR = 7'h2C
) (
    // Resolved bus lines
    input wire logic scl,
    input wire logic sda,
    // High while the model pulls the data line low
    output logic sda_oe,
    // Recorded traffic
    output logic [7:0] addr_byte,
    output logic [7:0] rx_first,
    output logic [7:0] rx_second,
    output int rx_count
);
    logic [7:0] shift;
    logic active;
    logic tx;
    logic rd_mode;
    int bit_cnt;
    int byte_no;

    initial begin
        sda_oe = 1'b0;
        active = 1'b0;
        rx_count = 0;
    end

    // Start and stop are the only data edges while the clock is high.
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            active = 1'b1;
            tx = 1'b0;
            rd_mode = 1'b0;
            bit_cnt = -1;
            byte_no = 0;
            rx_count = 0;
        end
    end

    always @(posedge sda) begin
        if (scl === 1'b1) begin
            active = 1'b0;
            sda_oe = 1'b0;
        end
    end

    always @(posedge scl) begin
        if (active && !tx && bit_cnt >= 0 && bit_cnt < 8) begin
            shift = {shift[6:0], sda};
        end
    end

    // Data moves only while the clock is low, so it never fakes a start.
    always @(negedge scl) begin
        if (active) begin
            bit_cnt = bit_cnt + 1;
            if (bit_cnt == 8) begin
                // Only its own address is acknowledged, so others see a NACK.
                sda_oe = !tx && (byte_no != 0 || shift[7:1] == OWN_ADDR);
                if (!tx && byte_no == 0) begin
                    addr_byte = shift;
                    rd_mode = shift[0];
                end else if (!tx) begin
                    if (rx_count == 0) begin
                        rx_first = shift;
                    end else begin
                        rx_second = shift;
                    end
                    rx_count = rx_count + 1;
                end
            end else if (bit_cnt == 9) begin
                bit_cnt = 0;
                byte_no = byte_no + 1;
                tx = rd_mode && byte_no == 1;
                sda_oe = tx && !READ_VALUE[7];
            end else if (tx) begin
                sda_oe = !READ_VALUE[7 - bit_cnt];
            end
        end
    end
endmodule : icmi_slave_model

//--- dv/tb.sv
`timescale 1ns/10ps
module tb import icmi_pkg::*;;
    localparam logic [7:0] RD_VALUE = 8'h5A;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = WORD_ZERO;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = WORD_ZERO;
    logic [31:0] hrdata;
    logic hreadyout, hresp, irq, scl_oe, sda_oe, slv_sda_oe;
    logic supply_fault_event = 1'b0;
    logic comparator_event = 1'b0;
    logic [7:0] slv_addr, slv_first, slv_second;
    logic [31:0] rd;
    int slv_count;
    int fail_count = 0;
    int n_compared = 0;
    wire scl_line;
    wire sda_line;

    // Open drain with pull-ups: a line is low while anyone pulls it.
    assign scl_line = !scl_oe;
    assign sda_line = !(sda_oe || slv_sda_oe);

    icmi_top icmi_top_inst (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .supply_fault_event(supply_fault_event),
        .comparator_event(comparator_event), .scl_in(scl_line),
        .scl_out(), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(),
        .sda_oe(sda_oe), .irq(irq));

    icmi_slave_model #(.READ_VALUE(RD_VALUE)) icmi_slave_model_inst (
        .scl(scl_line), .sda(sda_line), .sda_oe(slv_sda_oe),
        .addr_byte(slv_addr), .rx_first(slv_first),
        .rx_second(slv_second), .rx_count(slv_count));

    always #5 clk_sys = ~clk_sys;

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail_count++;
                results();
            end
            @(posedge clk_sys);
        end
    endtask : wait_ready

    // Entered just after a rising edge; returns at the data phase edge.
    task automatic bus(input logic wr_en, input logic [15:0] idx,
            input logic [7:0] wdata, output logic [31:0] rdata);
        hsel <= 1'b1;
        haddr <= {ADDR_TOP_ZERO, idx, ADDR_LOW_ZERO};
        hwrite <= wr_en;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h000000, wdata};
        wait_ready();
        rdata = hrdata;
    endtask : bus

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        bus(1'b1, idx, d, unused);
    endtask : wr

    task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, rd);
        check(rd, {24'h000000, exp});
    endtask : rchk

    // Polling is spaced out because a frame lasts tens of thousands of cycles.
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            repeat (100) @(posedge clk_sys);
            bus(1'b0, SERIAL_CTRL_IDX, 8'h00, rd);
            n++;
        end while (rd[CTRL_BUSY_BIT] !== 1'b0 && n < 500);
        if (n >= 500) begin
            fail_count++;
            results();
        end
    endtask : wait_idle

    task automatic test_reset;
        rchk(SECOND_WRITE_IDX, BYTE_RESET);
        rchk(READ_BYTE_IDX, BYTE_RESET);
        rchk(MISC_IRQ_IDX, BYTE_RESET);
        rchk(16'hFF90, BYTE_RESET);
        check({31'h00000000, irq}, 32'h00000000);
        check({31'h00000000, hresp}, 32'h00000000);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_two_byte;
        wr(MISC_IRQ_IDX, 8'h08);
        wr(SLAVE_ADDR_IDX, 8'h2C);
        wr(FIRST_WRITE_IDX, 8'h3C);
        wr(SECOND_WRITE_IDX, 8'hC3);
        rchk(SECOND_WRITE_IDX, 8'hC3);
        wr(SERIAL_CTRL_IDX, 8'h03);
        wait_idle();
        check(slv_addr, 32'h00000058);
        check(slv_count, 32'h00000002);
        check(slv_first, 32'h0000003C);
        check(slv_second, 32'h000000C3);
        rchk(MISC_IRQ_IDX, 8'h0C);
        check({31'h00000000, irq}, 32'h00000001);
        wr(MISC_IRQ_IDX, 8'h00);
        repeat (3) @(posedge clk_sys);
        check({31'h00000000, irq}, 32'h00000000);
        rchk(MISC_IRQ_IDX, 8'h04);
        $display("test_two_byte done");
    endtask : test_two_byte

    task automatic test_read_and_single;
        wr(SERIAL_CTRL_IDX, 8'h06);
        rchk(MISC_IRQ_IDX, 8'h00);
        wait_idle();
        check(slv_addr, 32'h00000059);
        rchk(READ_BYTE_IDX, RD_VALUE);
        rchk(MISC_IRQ_IDX, 8'h04);
        wr(FIRST_WRITE_IDX, 8'hA5);
        wr(SERIAL_CTRL_IDX, 8'h02);
        wait_idle();
        check(slv_count, 32'h00000001);
        check(slv_first, 32'h000000A5);
        $display("test_read_and_single done");
    endtask : test_read_and_single

    task automatic test_nack;
        wr(SLAVE_ADDR_IDX, 8'h11);
        wr(SERIAL_CTRL_IDX, 8'h02);
        wait_idle();
        check(rd, 32'h00000040);
        check(slv_count, 32'h00000000);
        rchk(MISC_IRQ_IDX, 8'h04);
        $display("test_nack done");
    endtask : test_nack

    task automatic test_events;
        wr(MISC_CLEAR_IDX, 8'h15);
        wr(MISC_IRQ_IDX, 8'h02);
        comparator_event <= 1'b1;
        supply_fault_event <= 1'b1;
        @(posedge clk_sys);
        comparator_event <= 1'b0;
        supply_fault_event <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rchk(MISC_IRQ_IDX, 8'h13);
        check({31'h00000000, irq}, 32'h00000001);
        wr(MISC_CLEAR_IDX, 8'h01);
        repeat (3) @(posedge clk_sys);
        check({31'h00000000, irq}, 32'h00000000);
        rchk(MISC_IRQ_IDX, 8'h12);
        wr(MISC_IRQ_IDX, 8'hFF);
        repeat (3) @(posedge clk_sys);
        check({31'h00000000, irq}, 32'h00000001);
        rchk(MISC_IRQ_IDX, 8'h3A);
        wr(MISC_CLEAR_IDX, 8'h10);
        rchk(MISC_IRQ_IDX, 8'h2A);
        check({31'h00000000, irq}, 32'h00000000);
        $display("test_events done");
    endtask : test_events

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        test_reset();
        test_two_byte();
        test_read_and_single();
        test_nack();
        test_events();
        results();
    end
endmodule : tb
